// *** src/preamp_serial_pkg.sv ***
// What this block does
// - A transaction is an 8-bit address word then an 8-bit data word.
// - Bits are taken on rising shift clock while enable is high, LSB first.
// - Enable falling before sixteen bits discards the access, registers kept.
// - Address bits 1,2 must match id pins, or both be one in servo write.
// - Address bits 3 to 6 pick register 0 to 11; bit 7 ignored.
// - Address bit 0 low starts a write, high starts a read.
// - Last eight bits before enable falls go into the register on the fall.
// - Read loads the register at once, bit 0 first, next bits on falls.
// - Short address is ignored; enable falling stops read output at once.
// - Servo write low with bits 1,2 both one addresses every device.
// - A fault drives the fault pin high in write mode and low in read mode.
// - Fault code in register 7 low nibble; cleared by resets and reg 9 write.
// - Fault code values follow the fixed fault table.
// - Read mode faults: reference, asperity, head open, supply, current, head, write-read short, overtemp.
// - Illegal head in read mode also diverts bias to the dummy head.
// - Write faults disable current except head open or grounded, slow data, write-read short or overtemp.
// - Disabled writer stays off until select goes high then low again.
// - Write requested in sleep or standby disables the write current.
// - The first of two close faults keeps its code.
// - Register reset pin low holds registers in reset and blocks writes.
// - Mode bits in register 9 pick mode; sleep after power-up.
// - Head values 0 to 11 are heads; 12 to 15 are illegal.
package preamp_serial_pkg;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 8;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_DONE = 5'h08;
    localparam int NUM_REGS = 12;
    localparam int GAP_NS = 75;
    // Register indices
    localparam logic [3:0] REG_HEAD_SELECT = 4'h0;
    localparam logic [3:0] REG_BIAS_IO_CONTROL = 4'h1;
    localparam logic [3:0] REG_READER_BIAS_GAIN = 4'h2;
    localparam logic [3:0] REG_READER_BANDWIDTH = 4'h3;
    localparam logic [3:0] REG_WRITER_CURRENT = 4'h4;
    localparam logic [3:0] REG_ASPERITY_THRESHOLD = 4'h5;
    localparam logic [3:0] REG_MAKER_CODE = 4'h6;
    localparam logic [3:0] REG_FAULT_REPORT = 4'h7;
    localparam logic [3:0] REG_MEASUREMENT_CONTROL = 4'h8;
    localparam logic [3:0] REG_MODE_CONTROL = 4'h9;
    localparam logic [3:0] REG_UNUSED_SLOT = 4'hA;
    localparam logic [3:0] REG_ASPERITY_COMPRESSOR = 4'hB;
    // Writable bit masks; other bits read zero or come from logic
    localparam logic [7:0] MASK_HEAD_SELECT = 8'hF8;
    localparam logic [7:0] MASK_BIAS_IO = 8'h7F;
    localparam logic [7:0] MASK_BANDWIDTH = 8'hF3;
    localparam logic [7:0] MASK_MEASURE = 8'h07;
    localparam logic [7:0] MASK_MODE = 8'h0F;
    localparam logic [7:0] MASK_COMPRESSOR = 8'h1F;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    // Field positions
    localparam int HEAD_SEL_LSB = 4;
    localparam int DIGON_BIT = 0;
    localparam int DUMMY_BIT = 7;
    localparam int READBACK_LEVEL_BIT = 3;
    localparam logic [3:0] FIRST_ILLEGAL_HEAD = 4'hC;
    // Operating modes in the two mode bits
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_ACTIVE = 2'h2;
    localparam logic [1:0] MODE_TEST = 2'h3;
    // Fault codes
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_WCUR_IN_READ = 4'h1;
    localparam logic [3:0] FC_ASPERITY = 4'h3;
    localparam logic [3:0] FC_READ_OPEN = 4'h4;
    localparam logic [3:0] FC_NO_WCUR = 4'h5;
    localparam logic [3:0] FC_WDATA_SLOW = 4'h6;
    localparam logic [3:0] FC_WHEAD_OPEN = 4'h7;
    localparam logic [3:0] FC_WHEAD_GND = 4'h8;
    localparam logic [3:0] FC_REFERENCE = 4'h9;
    localparam logic [3:0] FC_WR_SHORT = 4'hA;
    localparam logic [3:0] FC_LOW_SUPPLY = 4'hB;
    localparam logic [3:0] FC_ILLEGAL_HEAD = 4'hD;
    localparam logic [3:0] FC_OVERTEMP = 4'hF;
    // Maker code: arbitrary neutral value
    localparam logic [7:0] MAKER_CODE_DEFAULT = 8'h5A;
endpackage

// *** src/preamp_serial_port.sv ***
`timescale 1ns/100ps
module preamp_serial_port #(
    parameter logic [7:0] MAKER_CODE = preamp_serial_pkg::MAKER_CODE_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_serial_enable_line,
    input wire logic i_serial_io_line,
    output logic o_serial_io_line,
    output logic o_serial_io_line_oe_n,
    input wire logic i_preamp_id_pin_0,
    input wire logic i_preamp_id_pin_1,
    input wire logic i_servo_write_pin_n,
    input wire logic i_read_write_select_n,
    input wire logic i_register_reset_pin_n,
    input wire logic i_det_wcur_in_read,
    input wire logic i_det_asperity,
    input wire logic i_det_read_open,
    input wire logic i_det_no_wcur,
    input wire logic i_det_wdata_slow,
    input wire logic i_det_whead_open,
    input wire logic i_det_whead_gnd,
    input wire logic i_det_reference,
    input wire logic i_det_wr_short,
    input wire logic i_det_low_supply,
    input wire logic i_det_overtemp,
    input wire logic [4:0] i_meas_code,
    output logic o_fault_out_pin,
    output logic o_fault_out_pin_oe_n,
    output logic o_write_current_en,
    output logic o_dummy_head_sel,
    output logic [3:0] o_head_sel,
    output logic [1:0] o_op_mode,
    output logic o_readback_level_select
);
    import preamp_serial_pkg::*;

    // ---------------- Serial clock domain ----------------
    logic [ADDR_BITS-1:0] addr_sr;
    logic [DATA_BITS-1:0] data_sr;
    logic [4:0] bit_cnt;
    logic rd_act;
    logic [DATA_BITS-1:0] rd_word;
    logic [2:0] out_idx;
    logic [ADDR_BITS-1:0] addr_full;
    logic id0_q, id1_q, stw_q;
    logic [7:0] regs [NUM_REGS];
    logic [3:0] fault_view;
    logic fresh;
    logic [4:0] cnt_now;

    function automatic logic cs_match(input logic [7:0] a, input logic id0,
                                      input logic id1, input logic stw_n);
        if (stw_n) begin
            return (a[1] == id0) && (a[2] == id1);
        end
        return a[1] && a[2];
    endfunction

    // Address as it stands once the eighth bit arrives
    assign addr_full = {i_serial_io_line, addr_sr[ADDR_BITS-1:1]};

    // Read mux; unused bits return zero
    function automatic logic [7:0] read_mux(input logic [3:0] idx);
        case (idx)
            REG_HEAD_SELECT: read_mux = {regs[0][7:3], 1'b0, id1_q, id0_q};
            REG_MAKER_CODE: read_mux = MAKER_CODE;
            REG_FAULT_REPORT: read_mux = {4'h0, fault_view};
            REG_MEASUREMENT_CONTROL: read_mux = regs[8][DIGON_BIT] ?
                {i_meas_code, regs[8][2:0]} : {5'h00, regs[8][2:0]};
            REG_UNUSED_SLOT: read_mux = 8'h00;
            default: read_mux = (idx < 4'hC) ? regs[idx] : 8'h00;
        endcase
    endfunction

    // Marks a new frame; the count restarts at its first rising edge so
    // the finished frame stays readable until the system side commits it
    always_ff @(posedge i_sclk or negedge i_serial_enable_line) begin
        if (!i_serial_enable_line) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Bits already taken in this frame
    assign cnt_now = fresh ? 5'h00 : bit_cnt;

    // Shift in on rising edges; frame words hold after enable falls
    always_ff @(posedge i_sclk) begin
        if (cnt_now != 5'h1F) begin
            bit_cnt <= cnt_now + 5'h01;
        end
        if (cnt_now < ADDR_DONE) begin
            addr_sr <= addr_full;
        end else begin
            data_sr <= {i_serial_io_line, data_sr[7:1]};
        end
    end

    // Read decode at the eighth rising edge
    always_ff @(posedge i_sclk or negedge i_serial_enable_line) begin
        if (!i_serial_enable_line) begin
            rd_act <= 1'b0;
            rd_word <= 8'h00;
        end else if (cnt_now == ADDR_DONE - 5'h01) begin
            if (addr_full[0] && cs_match(addr_full, id0_q, id1_q, stw_q)
                && addr_full[6:3] < 4'hC) begin
                rd_act <= 1'b1;
                rd_word <= read_mux(addr_full[6:3]);
            end
        end
    end

    // Bit index advances on falling edges after the address
    always_ff @(negedge i_sclk or negedge i_serial_enable_line) begin
        if (!i_serial_enable_line) begin
            out_idx <= 3'h0;
        end else if (bit_cnt >= ADDR_DONE) begin
            out_idx <= bit_cnt[2:0];
        end
    end

    // Serial line driven only during read data; enable low drops it
    assign o_serial_io_line = rd_word[out_idx];
    assign o_serial_io_line_oe_n = ~rd_act;

    // ---------------- System clock domain ----------------
    logic sen_s1, sen_s2, sen_s3;
    logic id0_s1, id1_s1, stw_s1, rwn_s1, rrst_s1, rwn_q, rrst_q;
    logic [10:0] det_s1, det_q;
    logic commit;
    logic wr_hit;
    logic [3:0] wr_idx;
    logic in_active, write_mode, illegal_head;
    logic [3:0] fault_code;
    logic [3:0] next_fault;
    logic wr_lock;
    logic regs_rst;

    // Two-flop synchronisers for control and detector pins; enable gets a third flop for edge detection
    always_ff @(posedge i_clk) begin
        sen_s1 <= i_serial_enable_line;
        sen_s2 <= sen_s1;
        sen_s3 <= sen_s2;
        id0_s1 <= i_preamp_id_pin_0;
        id0_q <= id0_s1;
        id1_s1 <= i_preamp_id_pin_1;
        id1_q <= id1_s1;
        stw_s1 <= i_servo_write_pin_n;
        stw_q <= stw_s1;
        rwn_s1 <= i_read_write_select_n;
        rwn_q <= rwn_s1;
        rrst_s1 <= i_register_reset_pin_n;
        rrst_q <= rrst_s1;
        det_s1 <= {i_det_overtemp, i_det_low_supply, i_det_wr_short,
                   i_det_reference, i_det_whead_gnd, i_det_whead_open,
                   i_det_wdata_slow, i_det_no_wcur, i_det_read_open,
                   i_det_asperity, i_det_wcur_in_read};
        det_q <= det_s1;
    end

    // Frame end: serial registers are frozen once the clock has stopped
    assign commit = sen_s3 && !sen_s2;
    assign wr_idx = addr_sr[6:3];
    assign wr_hit = commit && bit_cnt >= FRAME_BITS && !addr_sr[0]
        && cs_match(addr_sr, id0_q, id1_q, stw_q) && rrst_q;
    assign regs_rst = i_srst || !rrst_q;

    // Register file with per-register writable masks
    always_ff @(posedge i_clk) begin
        if (regs_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RESET_VALUE;
            end
        end else if (wr_hit) begin
            case (wr_idx)
                REG_HEAD_SELECT: regs[0] <= data_sr & MASK_HEAD_SELECT;
                REG_BIAS_IO_CONTROL: regs[1] <= data_sr & MASK_BIAS_IO;
                REG_READER_BIAS_GAIN: regs[2] <= data_sr;
                REG_READER_BANDWIDTH: regs[3] <= data_sr & MASK_BANDWIDTH;
                REG_WRITER_CURRENT: regs[4] <= data_sr;
                REG_ASPERITY_THRESHOLD: regs[5] <= data_sr;
                REG_MEASUREMENT_CONTROL: regs[8] <= data_sr & MASK_MEASURE;
                REG_MODE_CONTROL: regs[9] <= data_sr & MASK_MODE;
                REG_ASPERITY_COMPRESSOR: regs[11] <= data_sr & MASK_COMPRESSOR;
                default: ;
            endcase
        end
    end

    assign in_active = regs[9][1:0] == MODE_ACTIVE
        || regs[9][1:0] == MODE_TEST;
    assign write_mode = !rwn_q;
    assign illegal_head = regs[0][7:4] >= FIRST_ILLEGAL_HEAD;

    // Lowest code wins among faults raised in the same cycle
    always_comb begin
        next_fault = FC_NONE;
        if (in_active) begin
            if (!write_mode) begin
                if (det_q[0]) next_fault = FC_WCUR_IN_READ;
                else if (det_q[1]) next_fault = FC_ASPERITY;
                else if (det_q[2]) next_fault = FC_READ_OPEN;
                else if (det_q[7]) next_fault = FC_REFERENCE;
                else if (det_q[8]) next_fault = FC_WR_SHORT;
                else if (det_q[9]) next_fault = FC_LOW_SUPPLY;
                else if (illegal_head) next_fault = FC_ILLEGAL_HEAD;
                else if (det_q[10]) next_fault = FC_OVERTEMP;
            end else begin
                if (det_q[3]) next_fault = FC_NO_WCUR;
                else if (det_q[4]) next_fault = FC_WDATA_SLOW;
                else if (det_q[5]) next_fault = FC_WHEAD_OPEN;
                else if (det_q[6]) next_fault = FC_WHEAD_GND;
                else if (det_q[7]) next_fault = FC_REFERENCE;
                else if (det_q[8]) next_fault = FC_WR_SHORT;
                else if (det_q[9]) next_fault = FC_LOW_SUPPLY;
                else if (illegal_head) next_fault = FC_ILLEGAL_HEAD;
                else if (det_q[10]) next_fault = FC_OVERTEMP;
            end
        end
    end

    // First fault is latched; a same-cycle clear wins over a held code
    always_ff @(posedge i_clk) begin
        if (regs_rst) begin
            fault_code <= FC_NONE;
        end else if (fault_code == FC_NONE && next_fault != FC_NONE) begin
            fault_code <= next_fault;
        end else if (wr_hit && wr_idx == REG_MODE_CONTROL) begin
            fault_code <= FC_NONE;
        end
    end

    // Readback copy only moves between frames so reads never tear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fault_view <= FC_NONE;
        end else if (!sen_s2) begin
            fault_view <= fault_code;
        end
    end

    // Writer lock: set by disabling faults or write from low power
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_lock <= 1'b0;
        end else if (write_mode && (!in_active
                     || next_fault == FC_NO_WCUR
                     || next_fault == FC_REFERENCE
                     || next_fault == FC_LOW_SUPPLY
                     || next_fault == FC_ILLEGAL_HEAD)) begin
            wr_lock <= 1'b1;
        end else if (!write_mode) begin
            wr_lock <= 1'b0;
        end
    end

    // Outputs
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_write_current_en <= 1'b0;
            o_dummy_head_sel <= 1'b1;
            o_fault_out_pin <= 1'b1;
            o_fault_out_pin_oe_n <= 1'b1;
        end else begin
            o_write_current_en <= write_mode && in_active && !wr_lock;
            o_dummy_head_sel <= !in_active || (!write_mode && (illegal_head
                || !regs[2][DUMMY_BIT]));
            o_fault_out_pin <= (fault_code != FC_NONE) ? write_mode
                : !write_mode;
            o_fault_out_pin_oe_n <= !in_active;
        end
    end

    assign o_head_sel = regs[0][7:HEAD_SEL_LSB];
    assign o_op_mode = regs[9][1:0];
    assign o_readback_level_select = regs[9][READBACK_LEVEL_BIT];
endmodule // preamp_serial_port

// *** tb/preamp_serial_port_assertions.sv ***
`timescale 1ns/100ps
module preamp_serial_port_checker (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_sclk,
    input wire logic i_serial_enable_line,
    input wire logic i_serial_io_line,
    input wire logic o_serial_io_line_oe_n,
    input wire logic i_preamp_id_pin_0,
    input wire logic i_preamp_id_pin_1,
    input wire logic i_servo_write_pin_n,
    input wire logic i_read_write_select_n,
    input wire logic i_det_low_supply,
    input wire logic i_det_no_wcur,
    input wire logic o_fault_out_pin,
    input wire logic o_fault_out_pin_oe_n,
    input wire logic o_write_current_en,
    input wire logic o_dummy_head_sel,
    input wire logic [3:0] o_head_sel,
    input wire logic [1:0] o_op_mode
);
    import preamp_serial_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic [4:0] nbit;
    logic [7:0] addr;
    logic hit;
    // Bits seen in this frame, cleared while enable is low
    always_ff @(posedge i_sclk or negedge i_serial_enable_line) begin
        if (!i_serial_enable_line) begin
            nbit <= 5'h00;
        end else if (nbit != 5'h1F) begin
            nbit <= nbit + 5'h01;
        end
    end
    // Address word as it went past
    always_ff @(posedge i_sclk) begin
        if (nbit < 5'h08) begin
            addr[nbit[2:0]] <= i_serial_io_line;
        end
    end
    assign hit = i_servo_write_pin_n
        ? addr[2:1] == {i_preamp_id_pin_1, i_preamp_id_pin_0}
        : addr[2:1] == 2'h3;
    sequence sleepy;
        !o_op_mode[1] [*2];
    endsequence
    sequence supply_read;
        $rose(i_det_low_supply) && o_op_mode[1] && i_read_write_select_n;
    endsequence
    sequence cut_fault;
        $rose(i_det_no_wcur) && o_write_current_en;
    endsequence
    sequence bad_head;
        (o_head_sel >= FIRST_ILLEGAL_HEAD && o_op_mode[1]
            && i_read_write_select_n) [*5];
    endsequence
    release_io_a: assert property (
        !i_serial_enable_line |-> o_serial_io_line_oe_n)
        else $error("read drive outlives the frame");
    read_count_a: assert property (
        !o_serial_io_line_oe_n |-> nbit >= 5'h08)
        else $error("read drive before the address word ends");
    read_match_a: assert property (
        !o_serial_io_line_oe_n |-> addr[0] && hit)
        else $error("read answered for a foreign address");
    sleep_write_a: assert property (
        sleepy |-> !o_write_current_en)
        else $error("write current on outside active mode");
    fault_float_a: assert property (
        sleepy |-> o_fault_out_pin_oe_n)
        else $error("fault pin driven in sleep or standby");
    read_no_write_a: assert property (
        i_read_write_select_n [*5] |-> !o_write_current_en)
        else $error("write current on in read mode");
    read_fault_a: assert property (
        supply_read |-> ##[1:6] !o_fault_out_pin)
        else $error("read fault not shown low");
    cut_write_a: assert property (
        cut_fault |-> ##[1:6] !o_write_current_en)
        else $error("write current kept after a cutting fault");
    bad_head_a: assert property (
        bad_head |-> o_dummy_head_sel)
        else $error("bias not on dummy head for illegal head");
    start_sleep_a: assert property (
        $fell(i_srst) |-> o_op_mode == MODE_SLEEP && !o_write_current_en)
        else $error("not asleep after reset");
endmodule // preamp_serial_port_checker
bind preamp_serial_port preamp_serial_port_checker checker_i (
    .i_clk, .i_srst, .i_sclk, .i_serial_enable_line, .i_serial_io_line,
    .o_serial_io_line_oe_n, .i_preamp_id_pin_0, .i_preamp_id_pin_1,
    .i_servo_write_pin_n, .i_read_write_select_n, .i_det_low_supply,
    .i_det_no_wcur, .o_fault_out_pin, .o_fault_out_pin_oe_n,
    .o_write_current_en, .o_dummy_head_sel, .o_head_sel, .o_op_mode
);

// *** tb/preamp_host_model.sv ***
`timescale 1ns/100ps
module preamp_host_model (
    output logic o_sclk,
    output logic o_sen,
    output logic o_sdo,
    input wire logic i_sdi
);
    // Link clock stands still and enable is low between frames
    initial begin
        o_sclk = 1'b0;
        o_sen = 1'b0;
        o_sdo = 1'b1;
    end
    // One frame, LSB first; n below 16 cuts it short
    task automatic frame(input logic [7:0] a, input logic [7:0] d,
                         input int n, output logic [7:0] q);
        q = 8'h00;
        o_sen = 1'b1;
        for (int i = 0; i < n; i++) begin
            if (i < 8) o_sdo = a[i];
            else if (a[0]) o_sdo = ~o_sdo; // Released for read data
            else o_sdo = d[i - 8];
            #12;
            if (i >= 8) q[i - 8] = i_sdi;
            o_sclk = 1'b1;
            #24;
            o_sclk = 1'b0;
            #12;
        end
        o_sen = 1'b0;
        o_sdo = ~o_sdo; // Line released
        #100;
    endtask
endmodule // preamp_host_model

// *** tb/preamp_serial_port_test.sv ***
`timescale 1ns/100ps
module preamp_serial_port_test;
    import preamp_serial_pkg::*;
    logic i_clk, i_srst, rrst_n, rws_n, servo_n, hi;
    logic o_io, oe_n, fpin, foe_n, wen, dummy, lvl, io;
    logic sclk, serial_enable_line, h_sdo;
    logic [1:0] asel, mode;
    logic [3:0] head;
    logic [10:0] det;
    logic [7:0] q;
    int num_errors = 0;
    int n_checks = 0;
    // Register, written value, expected read
    logic [19:0] tab [10] = '{20'h1FF7F, 20'h2A5A5, 20'h3FFF3, 20'h43C3C,
        20'h5C3C3, {12'h600, MAKER_CODE_DEFAULT}, 20'h8FFAF, 20'hAFF00,
        20'hBFF1F, 20'h0A8AA};
    assign io = oe_n ? h_sdo : o_io;
    preamp_host_model preamp_host_model_i (.o_sclk(sclk), .o_sen(serial_enable_line),
        .o_sdo(h_sdo), .i_sdi(io));
    preamp_serial_port preamp_serial_port_i (.i_clk(i_clk),
        .i_srst(i_srst), .i_sclk(sclk), .i_serial_enable_line(serial_enable_line),
        .i_serial_io_line(io), .o_serial_io_line(o_io),
        .o_serial_io_line_oe_n(oe_n), .i_preamp_id_pin_0(1'b0),
        .i_preamp_id_pin_1(1'b1), .i_servo_write_pin_n(servo_n),
        .i_read_write_select_n(rws_n), .i_register_reset_pin_n(rrst_n),
        .i_det_wcur_in_read(det[0]), .i_det_asperity(det[1]),
        .i_det_read_open(det[2]), .i_det_no_wcur(det[3]),
        .i_det_wdata_slow(det[4]), .i_det_whead_open(det[5]),
        .i_det_whead_gnd(det[6]), .i_det_reference(det[7]),
        .i_det_wr_short(det[8]), .i_det_low_supply(det[9]),
        .i_det_overtemp(det[10]), .i_meas_code(5'h15),
        .o_fault_out_pin(fpin), .o_fault_out_pin_oe_n(foe_n),
        .o_write_current_en(wen), .o_dummy_head_sel(dummy),
        .o_head_sel(head), .o_op_mode(mode),
        .o_readback_level_select(lvl));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task wr(input logic [3:0] r, input logic [7:0] d, input int n = 16);
        preamp_host_model_i.frame({hi, r, asel, 1'b0}, d, n, q);
    endtask
    task rd(input logic [3:0] r, input logic [7:0] e,
            input logic [7:0] m = 8'hFF);
        preamp_host_model_i.frame({hi, r, asel, 1'b1}, 8'h00, 16, q);
        check(q & m, e);
    endtask
    task summarize;
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #300000;
        num_errors++;
        summarize;
    end
    // Main sequence
    initial begin
        {i_srst, rrst_n, rws_n, servo_n, hi, asel, det} = {5'h17, 2'h2, 11'h0};
        tick(4);
        i_srst = 1'b0;
        tick(2);
        check({mode, wen, foe_n, dummy}, 5'h03);
        wr(4'h1, 8'h55);
        rrst_n = 1'b1;
        tick(6);
        rd(4'h1, 8'h00);
        foreach (tab[k]) begin
            wr(tab[k][19:16], tab[k][15:8]);
            rd(tab[k][19:16], tab[k][7:0]);
        end
        check(head, 4'hA);
        wr(4'h1, 8'h00, 12);
        preamp_host_model_i.frame({hi, 4'h1, asel, 1'b1}, 8'h0, 5, q);
        rd(4'h1, 8'h7F);
        asel = 2'h1;
        wr(4'h1, 8'h00);
        servo_n = 1'b0;
        asel = 2'h2;
        wr(4'h1, 8'h00);
        asel = 2'h3;
        rd(4'h1, 8'h7F);
        wr(4'h1, 8'h11);
        rd(4'h1, 8'h11);
        {servo_n, hi, asel} = 4'hE;
        wr(4'h3, 8'h30);
        rd(4'h3, 8'h30);
        hi = 1'b0;
        wr(4'h9, 8'h0A);
        check({lvl, mode, dummy}, 4'hC);
        det[1] = 1'b1;
        tick(8);
        check(fpin, 1'b0);
        det[9] = 1'b1;
        tick(8);
        det = '0;
        rd(4'h7, FC_ASPERITY, 8'h0F);
        wr(4'h9, 8'h0A);
        rd(4'h7, FC_NONE, 8'h0F);
        check(fpin, 1'b1);
        wr(4'h0, 8'hC0);
        check(dummy, 1'b1);
        rd(4'h7, FC_ILLEGAL_HEAD, 8'h0F);
        wr(4'h0, 8'h30);
        wr(4'h9, 8'h0A);
        rws_n = 1'b0;
        tick(8);
        check({wen, fpin}, 2'h2);
        det[5] = 1'b1;
        tick(8);
        check({wen, fpin}, 2'h3);
        det = '0;
        rd(4'h7, FC_WHEAD_OPEN, 8'h0F);
        wr(4'h9, 8'h0A);
        det[3] = 1'b1;
        tick(8);
        det = '0;
        wr(4'h9, 8'h0A);
        check(wen, 1'b0);
        rws_n = 1'b1;
        tick(8);
        rws_n = 1'b0;
        tick(8);
        check(wen, 1'b1);
        wr(4'h9, 8'h00);
        check(wen, 1'b0);
        wr(4'h9, 8'h0A);
        check(wen, 1'b0);
        rws_n = 1'b1;
        wr(4'h9, 8'h00);
        det = '1;
        tick(8);
        rd(4'h7, FC_NONE, 8'h0F);
        check(foe_n, 1'b1);
        det = '0;
        i_srst = 1'b1;
        tick(4);
        i_srst = 1'b0;
        tick(4);
        rd(4'h1, 8'h00);
        summarize;
    end
endmodule // preamp_serial_port_test
